// *** tmc_pkg.sv ***
// tmc_pkg: constants, modes and states for the tape motion control block
`default_nettype none
package tmc_pkg;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int unsigned TMC_CLK_HZ = 25000000;
  localparam int unsigned TMC_PRESET_US = 100;
  localparam int unsigned TMC_PRESET_CYCLES = (TMC_PRESET_US * (TMC_CLK_HZ / 1000000));
  localparam int unsigned TMC_PRESET_W = 13;
  // ----------------------------------------
  // configuration codes
  // ----------------------------------------
  localparam logic TMC_INPUT_PAIRED = 1'h0;
  localparam logic TMC_INPUT_THREE = 1'h1;
  localparam logic TMC_BRAKE_SINGLE = 1'h0;
  localparam logic TMC_BRAKE_DUAL = 1'h1;
  // ----------------------------------------
  // direction latch encoding
  // ----------------------------------------
  localparam logic TMC_DIR_FWD = 1'h0;
  localparam logic TMC_DIR_REV = 1'h1;
  // ----------------------------------------
  // motion states, one-hot
  // ----------------------------------------
  typedef enum logic [3:0] {
    TMC_FWD_STOP = 4'h1,
    TMC_FWD_RUN = 4'h2,
    TMC_REV_STOP = 4'h4,
    TMC_REV_RUN = 4'h8
  } tmc_motion_t;
endpackage
`default_nettype wire

// *** tmc_command_input_conditioner.sv ***
// tmc_command_input_conditioner: synchroniser and level/edge detection for one command line
`default_nettype none
module tmc_command_input_conditioner
  import tmc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // raw command lines: level active low, pulse of either polarity
  input wire logic level_n,
  input wire logic pulse_in,
  // conditioned active-high command, one cycle per accepted command
  output logic cmd
);
  logic [1:0] lvl_sync;
  logic [1:0] pls_sync;
  logic lvl_prev;
  logic pls_prev;
  wire level_active = ~lvl_sync[1];
  wire level_start = level_active & ~lvl_prev;
  // a pulse of either polarity triggers on its rising edge only; the pulse
  // path resets high so a line resting low or high gives no false edge
  wire pulse_rise = pls_sync[1] & ~pls_prev;
  wire next_cmd = level_start | pulse_rise;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lvl_sync <= 2'h3;
      pls_sync <= 2'h3;
      lvl_prev <= 1'h0;
      pls_prev <= 1'h1;
      cmd <= 1'h0;
    end else begin
      lvl_sync <= {lvl_sync[0], level_n};
      pls_sync <= {pls_sync[0], pulse_in};
      lvl_prev <= level_active;
      pls_prev <= pls_sync[1];
      cmd <= next_cmd;
    end
  end
endmodule
`default_nettype wire

// *** tmc_tape_motion_control.sv ***
// tmc_tape_motion_control: run/stop and direction latches with solenoid combiner
`default_nettype none
module tmc_tape_motion_control
  import tmc_pkg::*;
#(
  parameter logic INPUT_MODE = TMC_INPUT_THREE,
  parameter logic BRAKE_MODE = TMC_BRAKE_SINGLE,
  parameter logic [TMC_PRESET_W-1:0] PRESET_CYCLES = TMC_PRESET_W'(TMC_PRESET_CYCLES)
)
(
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // paired-line inputs, active low
  input wire logic forward_line_n,
  input wire logic reverse_line_n,
  // three-command inputs: level lines active low, pulse lines
  input wire logic forward_level_cmd,
  input wire logic forward_pulse_cmd,
  input wire logic reverse_level_cmd,
  input wire logic reverse_pulse_cmd,
  input wire logic halt_level_cmd,
  input wire logic halt_pulse_cmd,
  // latch state
  output logic run,
  output logic stop,
  output logic reverse_dir,
  output logic preset_active,
  // solenoids, high energises
  output logic fwd_drive,
  output logic rev_drive,
  output logic fwd_brake,
  output logic rev_brake
);
  // ----------------------------------------
  // reset release
  // ----------------------------------------
  logic [1:0] rst_sync;
  wire rst_n = rst_sync[1];
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'h1};
    end
  end

  // ----------------------------------------
  // three-command conditioners
  // ----------------------------------------
  logic [2:0] cond_cmd;
  wire [2:0] lvl_bus = {halt_level_cmd, reverse_level_cmd, forward_level_cmd};
  wire [2:0] pls_bus = {halt_pulse_cmd, reverse_pulse_cmd, forward_pulse_cmd};
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_cond
      tmc_command_input_conditioner u_cond (
        .clk(clk),
        .rst_n(rst_n),
        .level_n(lvl_bus[gi]),
        .pulse_in(pls_bus[gi]),
        .cmd(cond_cmd[gi])
      );
    end
  endgenerate

  // ----------------------------------------
  // paired-line synchroniser and decode
  // ----------------------------------------
  logic [1:0] fl_sync;
  logic [1:0] rl_sync;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fl_sync <= 2'h3;
      rl_sync <= 2'h3;
    end else begin
      fl_sync <= {fl_sync[0], forward_line_n};
      rl_sync <= {rl_sync[0], reverse_line_n};
    end
  end
  // both low is not a legal pair; it is treated as stop
  wire pair_fwd = ~fl_sync[1] & rl_sync[1];
  wire pair_rev = fl_sync[1] & ~rl_sync[1];
  wire pair_stop = ~(pair_fwd | pair_rev);

  // ----------------------------------------
  // command selection
  // ----------------------------------------
  wire paired = (INPUT_MODE == TMC_INPUT_PAIRED);
  wire go_fwd = paired ? pair_fwd : cond_cmd[0];
  wire go_rev = paired ? pair_rev : cond_cmd[1];
  // stop wins so a run request arriving together with a stop never runs tape
  wire go_stop = paired ? pair_stop : cond_cmd[2];

  // ----------------------------------------
  // power-up preset
  // ----------------------------------------
  logic [TMC_PRESET_W-1:0] preset_cnt;
  wire preset_done = (preset_cnt == PRESET_CYCLES);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      preset_cnt <= '0;
      preset_active <= 1'h1;
    end else begin
      if (!preset_done) begin
        preset_cnt <= preset_cnt + TMC_PRESET_W'(1);
      end
      preset_active <= ~preset_done;
    end
  end

  // ----------------------------------------
  // run/stop and direction latches
  // ----------------------------------------
  logic run_stop_latch;
  logic direction_latch;
  // a run request is ignored while the preset holds the transport stopped
  wire run_clear = preset_active | go_stop;
  wire run_request = go_fwd | go_rev;
  wire next_run = run_clear ? 1'h0 : (run_request ? 1'h1 : run_stop_latch);
  // direction only moves on a run request; stop leaves it alone
  wire dir_hold = preset_active | go_stop;
  wire next_dir = dir_hold ? direction_latch : (go_rev ? TMC_DIR_REV : (go_fwd ? TMC_DIR_FWD : direction_latch));
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      run_stop_latch <= 1'h0;
      direction_latch <= TMC_DIR_FWD;
    end else begin
      run_stop_latch <= next_run;
      direction_latch <= next_dir;
    end
  end

  // ----------------------------------------
  // solenoid combiner
  // ----------------------------------------
  wire dual = (BRAKE_MODE == TMC_BRAKE_DUAL);
  wire is_rev = (direction_latch == TMC_DIR_REV);
  wire next_fwd_drive = run_stop_latch & ~is_rev;
  wire next_rev_drive = run_stop_latch & is_rev;
  // one brake on its own side, or both when the transport has two brakes
  function automatic logic brake_sel(input logic running, input logic own_side, input logic both);
    return ~running & (both | own_side);
  endfunction
  wire next_fwd_brake = brake_sel(run_stop_latch, ~is_rev, dual);
  wire next_rev_brake = brake_sel(run_stop_latch, is_rev, dual);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      run <= 1'h0;
      stop <= 1'h1;
      reverse_dir <= 1'h0;
      fwd_drive <= 1'h0;
      rev_drive <= 1'h0;
      fwd_brake <= 1'h1;
      // a dual-brake transport holds both brakes on from reset onward
      rev_brake <= (BRAKE_MODE == TMC_BRAKE_DUAL);
    end else begin
      run <= run_stop_latch;
      stop <= ~run_stop_latch;
      reverse_dir <= is_rev;
      fwd_drive <= next_fwd_drive;
      rev_drive <= next_rev_drive;
      fwd_brake <= next_fwd_brake;
      rev_brake <= next_rev_brake;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence s_rev_req;
    paired && pair_rev && !preset_active;
  endsequence
  sequence s_rev_run;
    ##1 run_stop_latch && is_rev ##1 rev_drive && !fwd_drive;
  endsequence
  a_paired_rev_run: assert property (@(posedge clk) disable iff (!rst_n) s_rev_req |-> s_rev_run)
    else $error("paired reverse request did not run reverse");

  a_paired_stop: assert property (@(posedge clk) disable iff (!rst_n)
    (paired && pair_stop) |-> ##2 (!run && stop))
    else $error("paired stop did not stop");

  a_stop_keeps_dir: assert property (@(posedge clk) disable iff (!rst_n)
    (go_stop && !go_fwd && !go_rev) |=> $stable(direction_latch))
    else $error("stop changed direction");

  a_single_brake: assert property (@(posedge clk) disable iff (!rst_n)
    (!dual && !run_stop_latch) |=> (fwd_brake != rev_brake) && !fwd_drive && !rev_drive)
    else $error("single brake stop wrong solenoids");

  a_run_one_drive: assert property (@(posedge clk) disable iff (!rst_n)
    run_stop_latch |=> (fwd_drive ^ rev_drive) && !fwd_brake && !rev_brake)
    else $error("run energised wrong solenoids");

  a_preset_holds: assert property (@(posedge clk) disable iff (!rst_n)
    preset_active |=> !run_stop_latch)
    else $error("tape ran during preset");

  a_fwd_cmd: assert property (@(posedge clk) disable iff (!rst_n)
    (go_fwd && !go_rev && !go_stop && !preset_active) |=> run_stop_latch && !is_rev)
    else $error("forward command not taken");

  a_rev_cmd: assert property (@(posedge clk) disable iff (!rst_n)
    (go_rev && !go_stop && !preset_active) |=> run_stop_latch && is_rev)
    else $error("reverse command not taken");

  a_dual_brakes: assert property (@(posedge clk) disable iff (!rst_n)
    (dual && !run_stop_latch) |=> fwd_brake && rev_brake && (rev_brake == !run))
    else $error("dual brake stop wrong");

  // ----------------------------------------
  // checks: paired lines
  // ----------------------------------------
  sequence s_fwd_req;
    paired && pair_fwd && !preset_active;
  endsequence
  sequence s_fwd_run;
    ##1 run_stop_latch && !is_rev ##1 fwd_drive && !rev_drive;
  endsequence
  a_paired_fwd_run: assert property (@(posedge clk) disable iff (!rst_n) s_fwd_req |-> s_fwd_run)
    else $error("paired forward request did not run forward");

  // both lines low is illegal from the controller; the transport must stop
  a_pair_conflict: assert property (@(posedge clk) disable iff (!rst_n)
    (paired && !fl_sync[1] && !rl_sync[1]) |-> ##2 (!run && stop))
    else $error("illegal line pair did not stop");

  // ----------------------------------------
  // checks: latches
  // ----------------------------------------
  a_stop_wins: assert property (@(posedge clk) disable iff (!rst_n)
    go_stop |=> !run_stop_latch)
    else $error("stop command did not clear run latch");

  a_rev_beats_fwd: assert property (@(posedge clk) disable iff (!rst_n)
    (go_rev && go_fwd && !go_stop && !preset_active) |=> is_rev)
    else $error("reverse did not win over forward");

  a_idle_holds: assert property (@(posedge clk) disable iff (!rst_n)
    (!go_stop && !go_fwd && !go_rev && !preset_active) |=> $stable(run_stop_latch) && $stable(direction_latch))
    else $error("latches moved with no command");

  a_three_fwd: assert property (@(posedge clk) disable iff (!rst_n)
    (!paired && cond_cmd[0] && !cond_cmd[1] && !cond_cmd[2] && !preset_active) |-> ##2 (run && !reverse_dir))
    else $error("forward command did not reach outputs");

  // ----------------------------------------
  // checks: power-up preset
  // ----------------------------------------
  // counts preset cycles independently of the preset counter, saturating
  logic [TMC_PRESET_W-1:0] preset_seen;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      preset_seen <= '0;
    end else if (preset_active && (preset_seen != '1)) begin
      preset_seen <= preset_seen + TMC_PRESET_W'(1);
    end
  end

  a_preset_ends: assert property (@(posedge clk) disable iff (!rst_n)
    preset_done |=> !preset_active)
    else $error("preset did not end");

  a_preset_stays: assert property (@(posedge clk) disable iff (!rst_n)
    !preset_done |=> preset_active)
    else $error("preset ended early");

  a_preset_length: assert property (@(posedge clk) disable iff (!rst_n)
    preset_active |-> (preset_seen <= PRESET_CYCLES))
    else $error("preset lasted too long");

  a_preset_floor: assert property (@(posedge clk) disable iff (!rst_n)
    !preset_active |-> (preset_seen >= PRESET_CYCLES))
    else $error("preset too short");

  a_preset_outputs: assert property (@(posedge clk) disable iff (!rst_n)
    preset_active |-> ##2 (stop && !fwd_drive && !rev_drive))
    else $error("drive energised during preset");

  // ----------------------------------------
  // checks: solenoid combiner
  // ----------------------------------------
  sequence s_single_fwd_stop;
    !dual && !run_stop_latch && !is_rev;
  endsequence
  sequence s_single_rev_stop;
    !dual && !run_stop_latch && is_rev;
  endsequence
  a_fwd_stop_brake: assert property (@(posedge clk) disable iff (!rst_n)
    s_single_fwd_stop |=> fwd_brake && !rev_brake && !fwd_drive && !rev_drive)
    else $error("forward stop wrong solenoids");

  a_rev_stop_brake: assert property (@(posedge clk) disable iff (!rst_n)
    s_single_rev_stop |=> rev_brake && !fwd_brake && !fwd_drive && !rev_drive)
    else $error("reverse stop wrong solenoids");

  a_rev_run_only: assert property (@(posedge clk) disable iff (!rst_n)
    (run_stop_latch && is_rev) |=> rev_drive && !fwd_drive && !fwd_brake && !rev_brake)
    else $error("reverse run wrong solenoids");

  a_fwd_run_only: assert property (@(posedge clk) disable iff (!rst_n)
    (run_stop_latch && !is_rev) |=> fwd_drive && !rev_drive && !fwd_brake && !rev_brake)
    else $error("forward run wrong solenoids");

  a_rev_brake_inv: assert property (@(posedge clk) disable iff (!rst_n)
    dual |-> (rev_brake == !run))
    else $error("reverse brake not inverse of run");

  a_stop_inverse: assert property (@(posedge clk) disable iff (!rst_n)
    stop != run)
    else $error("stop output not inverse of run");

  a_dir_output: assert property (@(posedge clk) disable iff (!rst_n)
    reverse_dir == $past(is_rev))
    else $error("direction output wrong");

  a_single_no_both: assert property (@(posedge clk) disable iff (!rst_n)
    !dual |-> !(fwd_brake && rev_brake))
    else $error("single brake energised both brakes");

  a_drive_exclusive: assert property (@(posedge clk) disable iff (!rst_n)
    !(fwd_drive && rev_drive))
    else $error("both drives energised");

  a_brake_vs_drive: assert property (@(posedge clk) disable iff (!rst_n)
    (fwd_drive || rev_drive) |-> (!fwd_brake && !rev_brake))
    else $error("brake energised while driving");
endmodule
`default_nettype wire

// *** tmc_controller_model.sv ***
// tmc_controller_model: external controller that issues tape motion commands
`default_nettype none
module tmc_controller_model (
  // clock
  input wire logic clk,
  // paired-line outputs, active low
  output logic forward_line_n,
  output logic reverse_line_n,
  // three-command outputs
  output logic forward_level_cmd,
  output logic forward_pulse_cmd,
  output logic reverse_level_cmd,
  output logic reverse_pulse_cmd,
  output logic halt_level_cmd,
  output logic halt_pulse_cmd
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // idle levels
  // ----------------------------------------
  // the halt pulse line rests high so that it can carry negative pulses
  initial begin
    forward_line_n = 1'b1;
    reverse_line_n = 1'b1;
    forward_level_cmd = 1'b1;
    forward_pulse_cmd = 1'b0;
    reverse_level_cmd = 1'b1;
    reverse_pulse_cmd = 1'b0;
    halt_level_cmd = 1'b1;
    halt_pulse_cmd = 1'b1;
  end
  // ----------------------------------------
  // command forms
  // ----------------------------------------
  // sel 0 forward, 1 reverse, 2 halt; lvl picks the level line, else a pulse
  task automatic drive(input int sel, input bit lvl, input bit on);
    case (sel)
      0: if (lvl) forward_level_cmd = ~on; else forward_pulse_cmd = on;
      1: if (lvl) reverse_level_cmd = ~on; else reverse_pulse_cmd = on;
      default: if (lvl) halt_level_cmd = ~on; else halt_pulse_cmd = ~on;
    endcase
  endtask
  task automatic send(input int sel, input bit lvl);
    @(negedge clk);
    drive(sel, lvl, 1'b1);
    repeat (4) @(negedge clk);
    drive(sel, lvl, 1'b0);
  endtask
  // both lines change together, as one pair
  task automatic pair(input logic f_n, input logic r_n);
    @(negedge clk);
    forward_line_n = f_n;
    reverse_line_n = r_n;
  endtask
endmodule
`default_nettype wire

// *** tmc_tape_motion_control_tb.sv ***
// tmc_tape_motion_control_tb: self-checking bench for the tape motion control block
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_fail++; $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module tmc_tape_motion_control_tb
  import tmc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // harness
  // ----------------------------------------
  logic clk = 1'b0;
  logic resetn = 1'b0;
  wire logic fl_n, rl_n, flv, fpl, rlv, rpl, hlv, hpl;
  // packed as run, stop, reverse_dir, fwd_drive, rev_drive, fwd_brake, rev_brake
  logic [6:0] out_a, out_b;
  logic pre_a, pre_b;
  int n_fail = 0;
  int cmp_count = 0;
  always #20 clk = ~clk;
  tmc_controller_model i_tmc_controller_model (.clk(clk), .forward_line_n(fl_n), .reverse_line_n(rl_n),
    .forward_level_cmd(flv), .forward_pulse_cmd(fpl), .reverse_level_cmd(rlv), .reverse_pulse_cmd(rpl),
    .halt_level_cmd(hlv), .halt_pulse_cmd(hpl));
  // preset shortened but kept longer than one command plus settling
  tmc_tape_motion_control #(.INPUT_MODE(TMC_INPUT_THREE), .BRAKE_MODE(TMC_BRAKE_SINGLE), .PRESET_CYCLES(13'h028))
    i_tmc_tape_motion_control (.clk(clk), .resetn(resetn), .forward_line_n(fl_n), .reverse_line_n(rl_n),
    .forward_level_cmd(flv), .forward_pulse_cmd(fpl), .reverse_level_cmd(rlv), .reverse_pulse_cmd(rpl),
    .halt_level_cmd(hlv), .halt_pulse_cmd(hpl), .run(out_a[6]), .stop(out_a[5]), .reverse_dir(out_a[4]),
    .preset_active(pre_a), .fwd_drive(out_a[3]), .rev_drive(out_a[2]), .fwd_brake(out_a[1]), .rev_brake(out_a[0]));
  tmc_tape_motion_control #(.INPUT_MODE(TMC_INPUT_PAIRED), .BRAKE_MODE(TMC_BRAKE_DUAL), .PRESET_CYCLES(13'h028))
    i_tmc_tape_motion_control_b (.clk(clk), .resetn(resetn), .forward_line_n(fl_n), .reverse_line_n(rl_n),
    .forward_level_cmd(flv), .forward_pulse_cmd(fpl), .reverse_level_cmd(rlv), .reverse_pulse_cmd(rpl),
    .halt_level_cmd(hlv), .halt_pulse_cmd(hpl), .run(out_b[6]), .stop(out_b[5]), .reverse_dir(out_b[4]),
    .preset_active(pre_b), .fwd_drive(out_b[3]), .rev_drive(out_b[2]), .fwd_brake(out_b[1]), .rev_brake(out_b[0]));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic wrap_up();
    if (n_fail == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // longer than the five-edge command latency
  task automatic settle();
    repeat (8) @(negedge clk);
  endtask
  task automatic cmd(input int sel, input bit lvl);
    i_tmc_controller_model.send(sel, lvl);
    settle();
  endtask
  task automatic pair_step(input logic f_n, input logic r_n, input logic [6:0] exp);
    i_tmc_controller_model.pair(f_n, r_n);
    settle();
    `CHK(out_b, exp)
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_preset();
    int n;
    n = 0;
    repeat (4) @(negedge clk);
    `CHK(out_a, 7'h22)
    `CHK(out_b, 7'h23)
    cmd(0, 1'b0);
    `CHK(pre_a, 1'b1)
    `CHK(pre_b, 1'b1)
    `CHK(out_a, 7'h22)
    while (pre_a !== 1'b0 && n < 100) begin
      @(negedge clk);
      n++;
    end
    if (n >= 100) begin
      n_fail++;
      wrap_up();
    end
    `CHK(pre_b, 1'b0)
  endtask
  task automatic t_three_cmds();
    cmd(0, 1'b1);
    `CHK(out_a, 7'h48)
    cmd(2, 1'b0);
    `CHK(out_a, 7'h22)
    cmd(1, 1'b0);
    `CHK(out_a, 7'h54)
    cmd(2, 1'b1);
    `CHK(out_a, 7'h31)
    cmd(0, 1'b0);
    `CHK(out_a, 7'h48)
  endtask
  task automatic t_paired_dual();
    pair_step(1'b1, 1'b0, 7'h54);
    pair_step(1'b1, 1'b1, 7'h33);
    pair_step(1'b0, 1'b1, 7'h48);
    pair_step(1'b1, 1'b1, 7'h23);
  endtask
  initial begin
    repeat (6) @(negedge clk);
    resetn = 1'b1;
    t_preset();
    t_three_cmds();
    t_paired_dual();
    wrap_up();
  end
endmodule
`default_nettype wire
